// ### rtl/uart_rx_check_pkg.sv
package uart_rx_check_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ              = 100_000_000;
  localparam int unsigned CLK_MHZ             = CLK_HZ / 1_000_000;
  // link silence after a transmission before the link is declared faulty
  localparam int unsigned COMM_TIMEOUT_US     = 200;
  localparam int unsigned COMM_TIMEOUT_CYCLES = COMM_TIMEOUT_US * CLK_MHZ;
  // gap between characters that closes an open frame (least time, rounded up)
  localparam int unsigned FRAME_GAP_NS        = 2000;
  localparam int unsigned FRAME_GAP_CYCLES    = (FRAME_GAP_NS * CLK_MHZ + 999) / 1000;

  // register byte offsets
  localparam logic [11:0] OFS_CONFIG  = 12'h000;
  localparam logic [11:0] OFS_SEED    = 12'h004;
  localparam logic [11:0] OFS_RXSTAT  = 12'h008;
  localparam logic [11:0] OFS_VSTAT   = 12'h00C;
  localparam logic [11:0] OFS_RXDATA  = 12'h010;

  // config fields
  localparam int unsigned CFG_AUTO_ALIVE = 0;
  localparam int unsigned CFG_ALERT_EN   = 1;
  localparam int unsigned CFG_DEVCNT_LSB = 8;
  localparam logic [7:0]  DEVCNT_RESET   = 8'h01;
  localparam logic [7:0]  SEED_RESET     = 8'h00;

  // receive status fields
  localparam int unsigned RXS_EMPTY      = 0;
  localparam int unsigned RXS_STOP       = 1;
  localparam int unsigned RXS_LAST       = 2;
  localparam int unsigned RXS_BYTE_ERR   = 3;
  localparam int unsigned RXS_LINE_ALERT = 4;
  localparam int unsigned RXS_OVERFLOW   = 5;

  // verification status fields; bits 7:0 form the appended status byte
  localparam int unsigned VS_COUNT_MISMATCH = 1;
  localparam int unsigned VS_AUTO_PACKET    = 4;
  localparam int unsigned VS_LINK_FAULT     = 5;
  localparam int unsigned VS_CHAIN_SAFETY   = 6;
  localparam int unsigned VS_BUF_FAULT      = 8;

  // crc
  localparam logic [7:0]  CRC_POLY_DEFAULT = 8'h07;
  localparam logic [7:0]  CRC_INIT         = 8'h00;

  // buffer
  localparam int unsigned RX_DEPTH_DEFAULT = 64;

  // ahb
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

  typedef enum logic [0:0] {FR_HUNT, FR_OPEN} frame_state_type;
  typedef enum logic [1:0] {RD_DATA, RD_STATUS, RD_PEC} read_phase_type;

endpackage : uart_rx_check_pkg

// ### rtl/cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
  parameter int unsigned CYCLES = 200
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic stop,
  output var  logic expired
);
  localparam int unsigned W = $clog2(CYCLES + 1);

  logic [W-1:0] count_q;
  logic         running_q;

  // down counter; a restart always wins so a busy link never times out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q   <= '0;
      running_q <= 1'b0;
    end else if (start) begin
      count_q   <= W'(CYCLES - 1);
      running_q <= 1'b1;
    end else if (stop) begin
      running_q <= 1'b0;
    end else if (running_q) begin
      if (count_q == '0) begin
        running_q <= 1'b0;
      end else begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // one-cycle pulse in the cycle after the count reaches zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= running_q & ~start & ~stop & (count_q == '0);
    end
  end
endmodule : cycle_timer
`default_nettype wire

// ### rtl/crc8_accum.sv
`timescale 1ns/1ps
`default_nettype none
module crc8_accum #(
  parameter logic [7:0] POLY = uart_rx_check_pkg::CRC_POLY_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [7:0] data,
  output var  logic [7:0] crc_q
);
  // msb-first crc over one byte
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc_step

  // clear takes priority over a byte in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= uart_rx_check_pkg::CRC_INIT;
    end else if (clr) begin
      crc_q <= uart_rx_check_pkg::CRC_INIT;
    end else if (en) begin
      crc_q <= crc_step(crc_q, data);
    end
  end
endmodule : crc8_accum
`default_nettype wire

// ### rtl/uart_rx_message_error_check.sv
// How it works
// - every message read back ends with the current verification status byte, then a check byte
// - a frame opened by a corrupt preamble is dropped, never buffered
// - link timeout with no stored frame sets the link fault flag
// - auto rolling count: device steps the seed and flags a mismatch
// - rolling count byte follows the check byte and is left out of it
// - each message carries a crc-8 check byte the host can recompute
// - a line or parity error in a byte read out sets line alert
// - line alert enable lets the device notify the host of line errors
// - a broken stop still closes on next stop, gap timeout or preamble
// - a corrupt stop may be stored as data, making the message longer
// - a preamble mid-message ends it and starts a new message
// - a stop mid-message ends it early with fewer bytes
// - status bit 6 flags a chain unit safety fault from the poll packet
// - status bit 5 flags a message link fault
// - status bit 4 flags a link fault in the automatic poll packet
// - status bit 4 also flags a poll packet buffer hardware fault
// - receive status bit 1 reports a stored message for host polling
`timescale 1ns/1ps
`default_nettype none
module uart_rx_message_error_check #(
  parameter int unsigned RX_DEPTH            = uart_rx_check_pkg::RX_DEPTH_DEFAULT,
  parameter int unsigned COMM_TIMEOUT_CYCLES = uart_rx_check_pkg::COMM_TIMEOUT_CYCLES,
  parameter logic [7:0]  CRC_POLY            = uart_rx_check_pkg::CRC_POLY_DEFAULT
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        char_valid,
  input  wire logic [7:0]  char_data,
  input  wire logic        char_preamble,
  input  wire logic        char_preamble_bad,
  input  wire logic        char_stop,
  input  wire logic        char_manchester_err,
  input  wire logic        char_parity_err,
  input  wire logic        tx_sent,
  input  wire logic        chain_unit_safety_event,
  input  wire logic        auto_packet_link_event,
  input  wire logic        auto_packet_buffer_event,
  output var  logic        line_error_notify
);
  localparam int unsigned AW = $clog2(RX_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  uart_rx_check_pkg::frame_state_type frame_q;
  uart_rx_check_pkg::read_phase_type  phase_q;
  logic [7:0]    mem_data [RX_DEPTH];
  logic          mem_err  [RX_DEPTH];
  logic          mem_last [RX_DEPTH];
  logic [AW-1:0] wr_ptr_q, commit_ptr_q, rd_ptr_q;
  logic [AW:0]   msg_count_q;
  logic [AW:0]   frame_len_q;
  logic          frame_ovf_q;
  logic [7:0]    last_byte_q, crc_prev_q;
  logic          auto_alive_q, alert_en_q;
  logic [7:0]    dev_count_q, seed_q;
  logic          link_fault_q, mismatch_q, safety_q, apl_fault_q, apb_fault_q;
  logic          line_alert_q, overflow_q, last_flag_q, byte_err_q;
  logic          wr_q;
  logic [11:0]   waddr_q;
  logic          acc, rd_acc, rx_pop_req, pop_data, pop_status, pop_pec;
  logic          is_data, store, close, commit, drop, full;
  logic          pec_bad, count_bad, gap_expired, comm_expired;
  logic [7:0]    crc_rx, crc_rd, status_byte, rd_byte;
  logic [31:0]   rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // receive framing
  assign is_data = char_valid & ~char_preamble & ~char_preamble_bad & ~char_stop;
  assign full    = (AW'(wr_ptr_q + 1'b1) == rd_ptr_q);
  assign store   = is_data & (frame_q == uart_rx_check_pkg::FR_OPEN) & ~full &
                   ~gap_expired;
  // any boundary closes an open frame, whatever ended the previous one
  assign close   = (frame_q == uart_rx_check_pkg::FR_OPEN) &
                   ((char_valid & (char_preamble | char_preamble_bad | char_stop))
                    | gap_expired);
  assign commit  = close & ~frame_ovf_q & (frame_len_q != '0);
  assign drop    = close & ~commit;

  // frame state: a bad preamble leaves the framer hunting, so its bytes are lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_q <= uart_rx_check_pkg::FR_HUNT;
    end else if (char_valid & char_preamble) begin
      frame_q <= uart_rx_check_pkg::FR_OPEN;
    end else if ((char_valid & (char_preamble_bad | char_stop)) | gap_expired) begin
      frame_q <= uart_rx_check_pkg::FR_HUNT;
    end
  end

  // byte store; the last-of-message mark is set once the frame is known to end
  always_ff @(posedge hclk) begin
    if (store) begin
      mem_data[wr_ptr_q] <= char_data;
      mem_err[wr_ptr_q]  <= char_manchester_err | char_parity_err;
      mem_last[wr_ptr_q] <= 1'b0;
    end else if (commit) begin
      mem_last[AW'(wr_ptr_q - 1'b1)] <= 1'b1;
    end
  end

  // write pointer rewinds to the last commit when a frame is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_q     <= '0;
      commit_ptr_q <= '0;
    end else if (store) begin
      wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
    end else if (commit) begin
      commit_ptr_q <= wr_ptr_q;
    end else if (drop) begin
      wr_ptr_q <= commit_ptr_q;
    end
  end

  // per-frame length, overflow mark and the check byte residue before the last byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_len_q <= '0;
      frame_ovf_q <= 1'b0;
      last_byte_q <= 8'h00;
      crc_prev_q  <= uart_rx_check_pkg::CRC_INIT;
    end else if (char_valid & char_preamble) begin
      frame_len_q <= '0;
      frame_ovf_q <= 1'b0;
      crc_prev_q  <= uart_rx_check_pkg::CRC_INIT;
    end else if (store) begin
      frame_len_q <= (AW+1)'(frame_len_q + 1'b1);
      last_byte_q <= char_data;
      crc_prev_q  <= crc_rx;
    end else if (is_data & (frame_q == uart_rx_check_pkg::FR_OPEN) & full) begin
      frame_ovf_q <= 1'b1;
    end
  end

  crc8_accum #(.POLY(CRC_POLY)) u_crc_rx (
    .clk   (hclk),
    .rst_n (hresetn),
    .clr   (char_valid & char_preamble),
    .en    (store),
    .data  (char_data),
    .crc_q (crc_rx)
  );

  // a zero residue means the check byte matched; the trailing count byte is skipped
  assign pec_bad   = auto_alive_q ? (crc_prev_q != 8'h00) : (crc_rx != 8'h00);
  assign count_bad = auto_alive_q & (frame_len_q > (AW+1)'(1)) &
                     (last_byte_q != 8'(seed_q + dev_count_q));

  cycle_timer #(.CYCLES(uart_rx_check_pkg::FRAME_GAP_CYCLES)) u_gap (
    .clk     (hclk),
    .rst_n   (hresetn),
    .start   (char_valid & (char_preamble | (is_data & (frame_q == uart_rx_check_pkg::FR_OPEN)))),
    .stop    (close),
    .expired (gap_expired)
  );

  // armed by each transmission, disarmed by the first stored frame
  cycle_timer #(.CYCLES(COMM_TIMEOUT_CYCLES)) u_comm (
    .clk     (hclk),
    .rst_n   (hresetn),
    .start   (tx_sent),
    .stop    (commit),
    .expired (comm_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait state, read data registered at the address phase
  assign acc    = hsel & htrans[1] & hready;
  assign rd_acc = acc & ~hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q    <= 1'b0;
      waddr_q <= 12'h000;
    end else begin
      wr_q    <= acc & hwrite;
      waddr_q <= haddr[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-out of stored messages: bytes, then status byte, then a fresh check byte
  assign rx_pop_req = rd_acc & (haddr[11:0] == uart_rx_check_pkg::OFS_RXDATA);
  assign pop_data   = rx_pop_req & (phase_q == uart_rx_check_pkg::RD_DATA) &
                      (rd_ptr_q != commit_ptr_q);
  assign pop_status = rx_pop_req & (phase_q == uart_rx_check_pkg::RD_STATUS);
  assign pop_pec    = rx_pop_req & (phase_q == uart_rx_check_pkg::RD_PEC);

  assign status_byte = {1'b0, safety_q, link_fault_q, apl_fault_q | apb_fault_q,
                        2'b00, mismatch_q, 1'b0};

  always_comb begin
    rd_byte = 8'h00;
    if (pop_data) begin
      rd_byte = mem_data[rd_ptr_q];
    end else if (pop_status) begin
      rd_byte = status_byte;
    end else if (pop_pec) begin
      rd_byte = crc_rd;
    end
  end

  crc8_accum #(.POLY(CRC_POLY)) u_crc_rd (
    .clk   (hclk),
    .rst_n (hresetn),
    .clr   (pop_pec),
    .en    (pop_data | pop_status),
    .data  (rd_byte),
    .crc_q (crc_rd)
  );

  // read phase and pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q  <= uart_rx_check_pkg::RD_DATA;
      rd_ptr_q <= '0;
    end else if (pop_data) begin
      rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
      if (mem_last[rd_ptr_q]) begin
        phase_q <= uart_rx_check_pkg::RD_STATUS;
      end
    end else if (pop_status) begin
      phase_q <= uart_rx_check_pkg::RD_PEC;
    end else if (pop_pec) begin
      phase_q <= uart_rx_check_pkg::RD_DATA;
    end
  end

  // stored message count; a message leaves after its check byte is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_count_q <= '0;
    end else if (commit & ~pop_pec) begin
      msg_count_q <= (AW+1)'(msg_count_q + 1'b1);
    end else if (pop_pec & ~commit) begin
      msg_count_q <= (AW+1)'(msg_count_q - 1'b1);
    end
  end

  // last popped byte: end-of-message and error marks for host checks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_flag_q <= 1'b0;
      byte_err_q  <= 1'b0;
    end else if (pop_data) begin
      last_flag_q <= mem_last[rd_ptr_q];
      byte_err_q  <= mem_err[rd_ptr_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_alive_q <= 1'b0;
      alert_en_q   <= 1'b0;
      dev_count_q  <= uart_rx_check_pkg::DEVCNT_RESET;
    end else if (wr_q & (waddr_q == uart_rx_check_pkg::OFS_CONFIG)) begin
      auto_alive_q <= hwdata[uart_rx_check_pkg::CFG_AUTO_ALIVE];
      alert_en_q   <= hwdata[uart_rx_check_pkg::CFG_ALERT_EN];
      dev_count_q  <= hwdata[uart_rx_check_pkg::CFG_DEVCNT_LSB +: 8];
    end
  end

  // software write of the seed beats the automatic step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seed_q <= uart_rx_check_pkg::SEED_RESET;
    end else if (wr_q & (waddr_q == uart_rx_check_pkg::OFS_SEED)) begin
      seed_q <= hwdata[7:0];
    end else if (commit & auto_alive_q) begin
      seed_q <= 8'(seed_q + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: write one to clear, a set in the same cycle wins
  function automatic logic w1c(input logic flag, input logic set, input logic clr);
    return (flag & ~clr) | set;
  endfunction : w1c

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_fault_q <= 1'b0;
      mismatch_q   <= 1'b0;
      safety_q     <= 1'b0;
      apl_fault_q  <= 1'b0;
      apb_fault_q  <= 1'b0;
    end else begin
      link_fault_q <= w1c(link_fault_q, comm_expired | (commit & pec_bad),
                          wr_q & (waddr_q == uart_rx_check_pkg::OFS_VSTAT) &
                          hwdata[uart_rx_check_pkg::VS_LINK_FAULT]);
      mismatch_q   <= w1c(mismatch_q, commit & count_bad,
                          wr_q & (waddr_q == uart_rx_check_pkg::OFS_VSTAT) &
                          hwdata[uart_rx_check_pkg::VS_COUNT_MISMATCH]);
      safety_q     <= w1c(safety_q, chain_unit_safety_event,
                          wr_q & (waddr_q == uart_rx_check_pkg::OFS_VSTAT) &
                          hwdata[uart_rx_check_pkg::VS_CHAIN_SAFETY]);
      apl_fault_q  <= w1c(apl_fault_q, auto_packet_link_event,
                          wr_q & (waddr_q == uart_rx_check_pkg::OFS_VSTAT) &
                          hwdata[uart_rx_check_pkg::VS_AUTO_PACKET]);
      apb_fault_q  <= w1c(apb_fault_q, auto_packet_buffer_event,
                          wr_q & (waddr_q == uart_rx_check_pkg::OFS_VSTAT) &
                          (hwdata[uart_rx_check_pkg::VS_AUTO_PACKET] |
                           hwdata[uart_rx_check_pkg::VS_BUF_FAULT]));
    end
  end

  // line alert is raised while bytes are read, so the host clears it afterwards
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_alert_q <= 1'b0;
      overflow_q   <= 1'b0;
    end else begin
      line_alert_q <= w1c(line_alert_q, pop_data & mem_err[rd_ptr_q],
                          wr_q & (waddr_q == uart_rx_check_pkg::OFS_RXSTAT) &
                          hwdata[uart_rx_check_pkg::RXS_LINE_ALERT]);
      overflow_q   <= w1c(overflow_q, close & frame_ovf_q,
                          wr_q & (waddr_q == uart_rx_check_pkg::OFS_RXSTAT) &
                          hwdata[uart_rx_check_pkg::RXS_OVERFLOW]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr[11:0] == uart_rx_check_pkg::OFS_CONFIG) begin
      rd_word[uart_rx_check_pkg::CFG_AUTO_ALIVE]      = auto_alive_q;
      rd_word[uart_rx_check_pkg::CFG_ALERT_EN]        = alert_en_q;
      rd_word[uart_rx_check_pkg::CFG_DEVCNT_LSB +: 8] = dev_count_q;
    end else if (haddr[11:0] == uart_rx_check_pkg::OFS_SEED) begin
      rd_word[7:0] = seed_q;
    end else if (haddr[11:0] == uart_rx_check_pkg::OFS_RXSTAT) begin
      rd_word[uart_rx_check_pkg::RXS_EMPTY]      = (rd_ptr_q == commit_ptr_q) &
                                                   (phase_q == uart_rx_check_pkg::RD_DATA);
      rd_word[uart_rx_check_pkg::RXS_STOP]       = (msg_count_q != '0);
      rd_word[uart_rx_check_pkg::RXS_LAST]       = last_flag_q;
      rd_word[uart_rx_check_pkg::RXS_BYTE_ERR]   = byte_err_q;
      rd_word[uart_rx_check_pkg::RXS_LINE_ALERT] = line_alert_q;
      rd_word[uart_rx_check_pkg::RXS_OVERFLOW]   = overflow_q;
    end else if (haddr[11:0] == uart_rx_check_pkg::OFS_VSTAT) begin
      rd_word[7:0]                             = status_byte;
      rd_word[uart_rx_check_pkg::VS_BUF_FAULT] = apb_fault_q;
    end else if (haddr[11:0] == uart_rx_check_pkg::OFS_RXDATA) begin
      rd_word[7:0] = rd_byte;
    end
  end

  // bus outputs from flops; the slave never stalls and always answers okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= uart_rx_check_pkg::HRESP_OKAY;
    end else begin
      hrdata    <= rd_acc ? rd_word : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= uart_rx_check_pkg::HRESP_OKAY;
    end
  end

  // host notification of line errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_error_notify <= 1'b0;
    end else begin
      line_error_notify <= line_alert_q & alert_en_q;
    end
  end
endmodule : uart_rx_message_error_check
`default_nettype wire

// ### bench/uart_rx_check_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module uart_rx_check_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        line_error_notify
);
  // taken address phases; read data is judged one edge later
  wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
  wire logic wr_cfg  = hsel && htrans[1] && hready && hwrite && haddr[11:0] == 12'h000;
  wire logic at_rxs  = haddr[11:0] == uart_rx_check_pkg::OFS_RXSTAT;
  wire logic at_vs   = haddr[11:0] == uart_rx_check_pkg::OFS_VSTAT;
  wire logic at_rxd  = haddr[11:0] == uart_rx_check_pkg::OFS_RXDATA;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stall or error");
  idle_zero_a: assert property (!$past(rd_take) |-> hrdata == 32'h0)
    else $error("hrdata outside read");
  unmapped_zero_a: assert property ($past(rd_take && haddr[11:0] > 12'h010) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rxstat_bits_a: assert property ($past(rd_take && at_rxs) |-> hrdata[31:6] == 26'h0)
    else $error("rx status upper bits");
  stored_full_a: assert property ($past(rd_take && at_rxs) && hrdata[1] |-> !hrdata[0])
    else $error("stored message but empty");
  status_layout_a: assert property ($past(rd_take && at_vs) |-> hrdata[31:9] == 23'h0 && !hrdata[0])
    else $error("status layout");
  buf_bit4_a: assert property ($past(rd_take && at_vs) && hrdata[8] |-> hrdata[4])
    else $error("buffer fault without bit 4");
  rxdata_byte_a: assert property ($past(rd_take && at_rxd) |-> hrdata[31:8] == 24'h0)
    else $error("rx data wider than a byte");
  // the enable gates the notify output, whatever the flag holds
  notify_off_a: assert property (wr_cfg ##1 !hwdata[1] |-> ##[1:2] !line_error_notify)
    else $error("notify with alert disabled");
endmodule : uart_rx_check_assertions
bind uart_rx_message_error_check uart_rx_check_assertions chk_u (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .line_error_notify);
`default_nettype wire

// ### bench/chain_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module chain_link_model (
  input  wire logic       hclk,
  output var  logic       char_valid,
  output var  logic [7:0] char_data,
  output var  logic [4:0] char_kind
);
  // kind bits: preamble, bad preamble, stop, manchester error, parity error
  initial begin
    char_valid = 1'h0;
    char_data  = 8'h00;
    char_kind  = 5'h00;
  end
  // idle lines show the inverse, so stale bytes never look fresh
  task automatic put(input logic [4:0] k, input logic [7:0] d);
    @(posedge hclk);
    char_valid <= 1'h1;
    char_data  <= d;
    char_kind  <= k;
    @(posedge hclk);
    char_valid <= 1'h0;
    char_data  <= ~d;
    char_kind  <= ~k;
  endtask : put
endmodule : chain_link_model
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned TMO  = 50;
  localparam logic [11:0] CFG  = uart_rx_check_pkg::OFS_CONFIG;
  localparam logic [11:0] SEED = uart_rx_check_pkg::OFS_SEED;
  localparam logic [11:0] RXS  = uart_rx_check_pkg::OFS_RXSTAT;
  localparam logic [11:0] VS   = uart_rx_check_pkg::OFS_VSTAT;
  localparam logic [11:0] RXD  = uart_rx_check_pkg::OFS_RXDATA;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic        rd_ph = 1'h0;
  logic        tx_sent = 1'h0;
  logic [2:0]  ev = 3'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] exp_q [$];
  logic [7:0]  m [$];
  int          err_total = 0;
  int          n_checks = 0;
  wire logic [31:0] hrdata;
  wire logic        hreadyout, hresp, line_error_notify, char_valid;
  wire logic [7:0]  char_data;
  wire logic [4:0]  char_kind;
  always #5 hclk = ~hclk;
  chain_link_model lm (.hclk, .char_valid, .char_data, .char_kind);
  // short link timeout keeps the silent-link case quick
  uart_rx_message_error_check #(.COMM_TIMEOUT_CYCLES(TMO)) dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .char_valid, .char_data,
    .char_preamble(char_kind[0]), .char_preamble_bad(char_kind[1]), .char_stop(char_kind[2]),
    .char_manchester_err(char_kind[3]), .char_parity_err(char_kind[4]), .tx_sent,
    .chain_unit_safety_event(ev[0]), .auto_packet_link_event(ev[1]),
    .auto_packet_buffer_event(ev[2]), .line_error_notify);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // address held until hready, then the data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= uart_rx_check_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd_ph <= 1'h0;
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'h0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr
  function automatic logic [7:0] crc8(input logic [7:0] q [$]);
    logic [7:0] c;
    c = uart_rx_check_pkg::CRC_INIT;
    foreach (q[i]) begin
      c = c ^ q[i];
      repeat (8) c = {c[6:0], 1'h0} ^ (c[7] ? uart_rx_check_pkg::CRC_POLY_DEFAULT : 8'h00);
    end
    return c;
  endfunction : crc8
  task automatic frame();
    lm.put(5'h01, 8'h55);
    foreach (m[i]) lm.put(5'h00, m[i]);
    lm.put(5'h04, 8'hAA);
  endtask : frame
  // bytes, status byte, then check byte over both
  task automatic drain(input logic [7:0] st);
    foreach (m[i]) rd(RXD, {24'h0, m[i]});
    rd(RXD, {24'h0, st});
    m.push_back(st);
    rd(RXD, {24'h0, crc8(m)});
  endtask : drain
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // the oldest note is compared as each read data phase completes
  always @(posedge hclk) if (rd_ph === 1'h1) chk("hrdata", exp_q.pop_front(), hrdata);
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(73544));
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(CFG, 32'h100);
    rd(RXS, 32'h1);
    rd(12'h020, 32'h0);
    repeat (3) m.push_back(8'($urandom));
    m.push_back(crc8(m));
    frame();
    rd(RXS, 32'h2);
    drain(8'h00);
    m = {8'h12, 8'h34};
    frame();
    drain(8'h20);
    wr(VS, 32'h20);
    // dropped frame, then the link timer runs out
    tx_sent <= 1'h1;
    @(posedge hclk);
    tx_sent <= 1'h0;
    lm.put(5'h02, 8'h00);
    lm.put(5'h00, 8'h00);
    lm.put(5'h04, 8'hAA);
    repeat (TMO + 10) @(posedge hclk);
    rd(RXS, 32'h5);
    rd(VS, 32'h20);
    wr(VS, 32'h20);
    m = {8'h00};
    lm.put(5'h01, 8'h55);
    lm.put(5'h00, 8'h00);
    frame();
    lm.put(5'h00, 8'h77);
    drain(8'h00);
    m = {8'h00};
    drain(8'h00);
    rd(RXD, 32'h0);
    rd(SEED, 32'h0);
    wr(CFG, 32'h102);
    m = {8'h00};
    lm.put(5'h01, 8'h55);
    lm.put(5'h18, 8'h00);
    repeat (uart_rx_check_pkg::FRAME_GAP_CYCLES + 10) @(posedge hclk);
    drain(8'h00);
    repeat (3) @(posedge hclk);
    chk("notify", 32'h1, {31'h0, line_error_notify});
    wr(CFG, 32'h301);
    wr(RXS, 32'h10);
    wr(SEED, 32'h5);
    for (int i = 0; i < 2; i++) begin
      m = {8'h3C};
      m.push_back(crc8(m));
      m.push_back(i == 0 ? 8'h08 : 8'h00);
      frame();
      drain({6'h0, i[0], 1'h0});
      rd(SEED, 32'(6 + i));
    end
    wr(VS, 32'h2);
    ev <= 3'h7;
    @(posedge hclk);
    ev <= 3'h0;
    rd(VS, 32'h150);
    wr(VS, 32'h100);
    rd(VS, 32'h50);
    wr(VS, 32'h50);
    rd(VS, 32'h0);
    results();
  end
endmodule : testbench
`default_nettype wire
